// ===== logic/fpe_capture.sv
/*
 fatal program error capture: latches stop context and cause flags.
 assumes error events are one-cycle pulses from the execution engine,
 synchronous to clock, with context valid in the same cycle.
*/
// What this block does
// RULE1: fatal error stops run, records task
// RULE2: cyclic task stored as 0000..001F
// RULE3: interrupt task stored as 8000+number
// RULE4: no active cyclic task stores FFFF
// RULE5: stop address split low/high words
// RULE6: missing end sets flag, expected address
// RULE7: task error sets flag, address FFFFFFF
// RULE8: three task execution error causes
// RULE9: operand error sets error flag; fatal if stop
// RULE10: illegal access sets access flag; fatal if stop
// RULE11: bad decimal indirect sets access flag too
// RULE12: over 131071 edits sets overflow flag
// RULE13: fetch past storage sets overflow flag
// RULE14: unexecutable code is fatal, flagged
// RULE15: stop selection defaults to continue
// RULE16: capture holds until reset or clear
`timescale 1ns/10ps
module fpe_capture
   import fpe_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             resetn,
   input  wire fpe_pkg::fpe_cause_t cause,     // error events, pulses
   input  wire fpe_pkg::fpe_ctx_t   ctx,       // task and address
   input  wire logic [17:0]      diff_count,   // edit diff count
   input  wire logic             op_ok,        // instruction ended fine
   input  wire logic [7:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic      [31:0]      reg_rdata,
   output logic                  run,          // program may execute
   output logic                  irq
);
   import fpe_pkg::*;

   // ==================================================================
   // state
   typedef enum logic [1:0] {
      ST_RUN  = 2'b01,   // executing
      ST_STOP = 2'b10    // halted by fatal error
   } fpe_state_t;

   fpe_state_t        state_r;        // run/stop state
   logic [15:0]       task_r;         // stopped_task_word
   logic [15:0]       addr_lo_r;      // stop_address_low_word
   logic [15:0]       addr_hi_r;      // stop_address_high_word
   logic [NFLAGS-1:0] flags_r;        // fatal flag bits
   logic              stop_sel_r;     // stop on instruction error
   logic              err_r;          // instruction_error_flag
   logic              acc_err_r;      // access_error_flag
   logic [2:0]        stat_r;         // sticky interrupt events
   logic [2:0]        mask_r;         // interrupt mask
   logic [NFLAGS-1:0] hit;            // fatal causes this cycle
   logic              fatal;          // any fatal cause this cycle
   logic              task_err;       // task execution error
   logic              diff_over;      // differentiation overflow
   logic              clr;            // software capture clear
   logic              wr_ctrl;        // control register write
   logic [15:0]       task_code;      // encoded task word
   logic [31:0]       stop_addr;      // address to store

   assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
   assign clr     = wr_ctrl && reg_wdata[CB_CLEAR];

   // ==================================================================
   // cause decode
   // RULE8: task error causes
   assign task_err = cause.no_task | cause.no_program | cause.no_int_task;
   // the count is a level: it keeps the cause up while the editor holds
   // it above the limit, which is harmless once the block has stopped
   // RULE12: count beyond limit
   assign diff_over = cause.diff_over ||
                      (diff_count > 18'(DIFF_LIMIT));

   always_comb begin
      hit = '0;
      // RULE9: fatal only when stop selected
      hit[FB_INSTR]   = cause.bad_operand & stop_sel_r;
      // RULE11: decimal fault fatal when stop selected
      hit[FB_INDIR]   = cause.bad_decimal & stop_sel_r;
      // RULE10: access fault fatal when stop selected
      hit[FB_ACCESS]  = cause.bad_access & stop_sel_r;
      hit[FB_NOEND]   = cause.no_end;
      hit[FB_TASK]    = task_err;
      hit[FB_DIFF]    = diff_over;
      // RULE14: unexecutable code flagged
      hit[FB_ILLEGAL] = cause.illegal_op;
      // RULE13: fetch past storage area
      hit[FB_UMOVF]   = cause.past_end;
   end
   // causes count only while running; a second fault while stopped must
   // not overwrite the first capture
   assign fatal = (|hit) && (state_r == ST_RUN);

   // ==================================================================
   // task word encoding
   // a cyclic number above 31 is cut to five bits; the engine sends none
   always_comb begin
      // RULE4: no cyclic task to run
      if (cause.no_task) begin
         task_code = TASK_NONE;
      end else if (ctx.is_int) begin
         // RULE3: interrupt base plus number
         task_code = TASK_INT_BASE | {8'h00, ctx.num};
      end else begin
         // RULE2: cyclic task 0 to 31
         task_code = {11'h000, ctx.num[4:0]};
      end
   end

   // address to store; task error wins over the others
   always_comb begin
      if (task_err) begin
         // RULE7: fixed marker address
         stop_addr = ADDR_TASK_ERR;
      end else begin
         // RULE6: expected end address arrives in ctx.addr
         stop_addr = ctx.addr;
      end
   end

   // ==================================================================
   // run/stop state machine
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_RUN;
      end else begin
         case (state_r)
            // RULE1: stop on any fatal cause
            ST_RUN:  if (fatal) begin
               state_r <= ST_STOP;
            end
            ST_STOP: if (clr) begin
               state_r <= ST_RUN;
            end
            default: state_r <= ST_RUN;
         endcase
      end
   end
   assign run = (state_r == ST_RUN);

   // ==================================================================
   // capture words; written once per stop and then frozen
   // a fault in the same cycle as a clear wins while running; while stopped the clear wins and the fault is lost
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         task_r    <= TASK_RST;
         addr_lo_r <= 16'h0000;
         addr_hi_r <= 16'h0000;
      end else if (fatal) begin
         // RULE1: record task of the stop
         task_r    <= task_code;
         // RULE5: low and high address words
         addr_lo_r <= stop_addr[15:0];
         addr_hi_r <= stop_addr[31:16];
      end else if (clr) begin
         // RULE16: only clear or reset releases capture
         task_r    <= TASK_RST;
         addr_lo_r <= 16'h0000;
         addr_hi_r <= 16'h0000;
      end
   end

   // fatal flags: one always block per bit from one generate loop, set wins over clear
   genvar gi;
   generate
      for (gi = 0; gi < NFLAGS; gi++) begin : g_flag
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               flags_r[gi] <= 1'b0;
            end else if (fatal && hit[gi]) begin
               flags_r[gi] <= 1'b1;
            end else if (clr) begin
               // RULE16: held until clear
               flags_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==================================================================
   // control register: stop selection
   // a clear write also rewrites the selection, so software must write
   // the selection it wants together with the clear bit
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         // RULE15: continue by default
         stop_sel_r <= STOP_RST;
      end else if (wr_ctrl) begin
         stop_sel_r <= reg_wdata[CB_STOP];
      end
   end

   // instruction error flag: set on bad operand, off after a clean end
   // a clean end in the same cycle as a new bad operand keeps the flag
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         err_r <= 1'b0;
      end else if (cause.bad_operand) begin
         // RULE9: error flag regardless of stop
         err_r <= 1'b1;
      end else if (op_ok) begin
         err_r <= 1'b0;
      end
   end

   // access error flag: not cleared by the task, only by software
   // any write to the error word clears it; a new fault in that cycle
   // keeps it set
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         acc_err_r <= 1'b0;
      end else if (cause.bad_access || cause.bad_decimal) begin
         // RULE10: access error flag
         // RULE11: decimal fault also raises it
         acc_err_r <= 1'b1;
      end else if (reg_wr && reg_addr == OFS_ERRS) begin
         acc_err_r <= 1'b0;
      end
   end

   // ==================================================================
   // interrupt: sticky events, cleared by reading, set wins
   logic [2:0] ev;                    // events raised this cycle
   // a read in the same cycle as an event keeps the new event, so no
   // interrupt cause is lost between one read and the next
   always_comb begin
      ev                = 3'h0;
      ev[SB_FATAL]      = fatal;
      ev[SB_ERR]        = cause.bad_operand;
      ev[SB_ACCERR]     = cause.bad_access | cause.bad_decimal;
   end
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stat_r <= 3'h0;
      end else if (reg_rd && reg_addr == OFS_STAT) begin
         stat_r <= ev;
      end else begin
         stat_r <= stat_r | ev;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         mask_r <= 3'h0;
      end else if (reg_wr && reg_addr == OFS_MASK) begin
         mask_r <= reg_wdata[2:0];
      end
   end
   assign irq = |(stat_r & mask_r);

   // ==================================================================
   // read port: data stand in the cycle after the strobe only
   // the port never stalls, so there is no wait state to count
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            OFS_TASK:    reg_rdata <= {16'h0000, task_r};
            OFS_ADDR_LO: reg_rdata <= {16'h0000, addr_lo_r};
            OFS_ADDR_HI: reg_rdata <= {16'h0000, addr_hi_r};
            OFS_FLAGS:   reg_rdata <= {24'h000000, flags_r};
            OFS_CTRL:    reg_rdata <= {31'h0, stop_sel_r};
            OFS_STAT:    reg_rdata <= {29'h0, stat_r};
            OFS_MASK:    reg_rdata <= {29'h0, mask_r};
            OFS_ERRS:    reg_rdata <= {30'h0, acc_err_r, err_r};
            // unmapped addresses read as zero
            default:     reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ==================================================================
   // checks
   // RULE16: stop is held
   a_stop_holds: assert property ( // RULE16
      @(posedge clock) disable iff (!resetn)
      (state_r == ST_STOP && !clr) |=> (state_r == ST_STOP))
      else $error("stop state left without clear");
   // RULE7: task error address
   a_task_err_addr: assert property ( // RULE7
      @(posedge clock) disable iff (!resetn)
      (fatal && task_err) |=> ({addr_hi_r, addr_lo_r} == 32'h0FFFFFFF))
      else $error("task error address wrong");
   // RULE4: no task word
   a_no_task_word: assert property ( // RULE4
      @(posedge clock) disable iff (!resetn)
      (fatal && cause.no_task) |=> (task_r == 16'hFFFF))
      else $error("no task word wrong");
   // RULE3: interrupt task word
   a_int_task_word: assert property ( // RULE3
      @(posedge clock) disable iff (!resetn)
      (fatal && !cause.no_task && ctx.is_int)
      |=> (task_r == (16'h8000 + $past(ctx.num))))
      else $error("interrupt task word wrong");
   // RULE2: cyclic task word
   a_cyc_task_word: assert property ( // RULE2
      @(posedge clock) disable iff (!resetn)
      (fatal && !cause.no_task && !ctx.is_int && ctx.num <= 8'h1F)
      |=> (task_r == {8'h00, $past(ctx.num)}))
      else $error("cyclic task word wrong");
   // RULE14: illegal code stops
   a_stop_on_fatal: assert property ( // RULE14
      @(posedge clock) disable iff (!resetn)
      (run && cause.illegal_op) |=> (!run && flags_r[FB_ILLEGAL]))
      else $error("illegal code did not stop");
   // RULE9: continue keeps running
   a_continue_mode: assert property ( // RULE9
      @(posedge clock) disable iff (!resetn)
      (run && !stop_sel_r && cause.bad_operand && !(|hit))
      |=> (run && err_r))
      else $error("continue mode stopped or lost error");
   // RULE10: access flag set
   a_access_flag: assert property ( // RULE10
      @(posedge clock) disable iff (!resetn)
      cause.bad_access |=> acc_err_r)
      else $error("access error flag not set");
   // RULE6: expected end address
   a_end_address: assert property ( // RULE6
      @(posedge clock) disable iff (!resetn)
      (fatal && cause.no_end && !task_err)
      |=> (addr_lo_r == $past(ctx.addr[15:0])
           && flags_r[FB_NOEND]))
      else $error("missing end capture wrong");
   // RULE13: overflow flag set
   a_umovf_flag: assert property ( // RULE13
      @(posedge clock) disable iff (!resetn)
      (run && cause.past_end) |=> flags_r[FB_UMOVF])
      else $error("overflow flag not set");
   // RULE8: task error flag
   a_task_err_flag: assert property ( // RULE8
      @(posedge clock) disable iff (!resetn)
      (run && (cause.no_task || cause.no_program || cause.no_int_task))
      |=> (!run && flags_r[FB_TASK]))
      else $error("task error not flagged");
   // RULE12: count overflow stops
   a_diff_stop: assert property ( // RULE12
      @(posedge clock) disable iff (!resetn)
      (run && diff_count > 18'(DIFF_LIMIT))
      |=> (!run && flags_r[FB_DIFF]))
      else $error("differentiation overflow not flagged");
   // RULE10: stop on access
   a_access_stop: assert property ( // RULE10
      @(posedge clock) disable iff (!resetn)
      (run && stop_sel_r && cause.bad_access)
      |=> (!run && flags_r[FB_ACCESS]))
      else $error("access fault did not stop");
   // RULE11: stop on decimal
   a_decimal_stop: assert property ( // RULE11
      @(posedge clock) disable iff (!resetn)
      (run && stop_sel_r && cause.bad_decimal)
      |=> (!run && flags_r[FB_INDIR] && acc_err_r))
      else $error("decimal fault did not stop");
   // RULE9: error flag set
   a_error_flag_set: assert property ( // RULE9
      @(posedge clock) disable iff (!resetn)
      cause.bad_operand |=> err_r)
      else $error("instruction error flag not set");
   // RULE16: capture frozen
   a_capture_frozen: assert property ( // RULE16
      @(posedge clock) disable iff (!resetn)
      (!run && !clr)
      |=> ($stable(task_r) && $stable(addr_lo_r)
           && $stable(addr_hi_r) && $stable(flags_r)))
      else $error("capture changed while stopped");
endmodule // fpe_capture

// ===== logic/fpe_pkg.sv
/*
 fatal program error capture: shared constants and carrier types.
 assumes a single clock domain and a plain strobe register port.
*/
package fpe_pkg;
   // ==================================================================
   // register map (byte offsets, one word each)
   localparam logic [7:0] OFS_TASK    = 8'h00; // stopped_task_word
   localparam logic [7:0] OFS_ADDR_LO = 8'h04; // stop_address_low_word
   localparam logic [7:0] OFS_ADDR_HI = 8'h08; // stop_address_high_word
   localparam logic [7:0] OFS_FLAGS   = 8'h0C; // fatal flag bits
   localparam logic [7:0] OFS_CTRL    = 8'h10; // stop select, clear
   localparam logic [7:0] OFS_STAT    = 8'h14; // sticky events
   localparam logic [7:0] OFS_MASK    = 8'h18; // interrupt mask
   localparam logic [7:0] OFS_ERRS    = 8'h1C; // error/access error flags
   // ==================================================================
   // fatal flag bit positions
   localparam int FB_INSTR   = 0;  // instruction_processing_fatal_flag
   localparam int FB_INDIR   = 1;  // indirect_decimal_fatal_flag
   localparam int FB_ACCESS  = 2;  // illegal_access_fatal_flag
   localparam int FB_NOEND   = 3;  // missing_end_flag
   localparam int FB_TASK    = 4;  // task_error_flag
   localparam int FB_DIFF    = 5;  // differentiation_overflow_flag
   localparam int FB_ILLEGAL = 6;  // illegal_instruction_flag
   localparam int FB_UMOVF   = 7;  // user_memory_overflow_flag
   localparam int NFLAGS     = 8;
   // control bits
   localparam int CB_STOP    = 0;  // stop on instruction error
   localparam int CB_CLEAR   = 1;  // write 1: clear capture
   // status bits
   localparam int SB_FATAL   = 0;
   localparam int SB_ERR     = 1;
   localparam int SB_ACCERR  = 2;
   // ==================================================================
   // stored values
   localparam logic [15:0] TASK_INT_BASE = 16'h8000;
   localparam logic [15:0] TASK_NONE     = 16'hFFFF;
   localparam logic [15:0] TASK_CYC_MAX  = 16'h001F;
   localparam logic [31:0] ADDR_TASK_ERR = 32'h0FFFFFFF;
   localparam logic [15:0] TASK_RST      = 16'h0000;
   localparam logic        STOP_RST      = 1'b0; // default: continue
   localparam int DIFF_LIMIT = 131071;
   // ==================================================================
   // carrier for the cause and context of an error report
   typedef struct packed {
      logic        no_end;       // end instruction not found
      logic        no_task;      // no task ready in the cycle
      logic        no_program;   // task has no program
      logic        no_int_task;  // interrupt task missing
      logic        bad_operand;  // invalid operand data
      logic        bad_access;   // illegal area access
      logic        bad_decimal;  // indirect address not decimal coded
      logic        diff_over;    // edit differentiation count too big
      logic        past_end;     // fetch past program storage area
      logic        illegal_op;   // unexecutable instruction code
   } fpe_cause_t;

   typedef struct packed {
      logic        is_int;       // running task is interrupt task
      logic [7:0]  num;          // task number
      logic [31:0] addr;         // program address at the event
   } fpe_ctx_t;
endpackage

// ===== test/test_fpe_capture.sv
/*
 self-checking bench for the fatal program error capture block.
 assumes one 100 MHz clock, an async active-low reset and the strobe
 register port with read data in the cycle after the read strobe.
*/
`timescale 1ns/10ps
module test_fpe_capture;
   import fpe_pkg::*;
   // ==================================================================
   // stimulus and observation
   logic        clock;      // 100 MHz
   logic        resetn;     // async, active low
   fpe_cause_t  cause;      // event pulses
   fpe_ctx_t    ctx;        // task and address beside the event
   logic [17:0] diff_count; // edit differentiation count
   logic        op_ok;      // instruction ended normally
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        run;
   logic        irq;
   int          fail_count; // mismatches
   int          tests_run;  // comparisons
   // flag bit expected for each cause, msb cause first
   int flag_of [10] = '{FB_NOEND, FB_TASK, FB_TASK, FB_TASK, FB_INSTR,
                        FB_ACCESS, FB_INDIR, FB_DIFF, FB_UMOVF,
                        FB_ILLEGAL};
   fpe_capture dut (.clock(clock), .resetn(resetn), .cause(cause),
      .ctx(ctx), .diff_count(diff_count), .op_ok(op_ok),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run(run), .irq(irq));
   // ==================================================================
   // clock and reset
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // ==================================================================
   // shared tasks
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // read, data sampled in the one cycle where it stands
   task automatic rd(logic [7:0] a, logic [31:0] e, string n,
                     logic [31:0] m = 32'hFFFFFFFF);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1;
      chk(n, e, reg_rdata & m);
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
      #1;
   endtask
   // one-cycle event with its context and edit count, all in one cycle
   task automatic fire(fpe_cause_t c, fpe_ctx_t x,
                       logic [17:0] d = '0);
      @(posedge clock);
      cause      <= c;
      ctx        <= x;
      diff_count <= d;
      @(posedge clock);
      cause      <= '0;
      diff_count <= '0;
      #1;
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ==================================================================
   // watchdog: the whole sequence needs well under 2,000 cycles
   initial begin
      #200000;
      fail_count++;
      end_of_test();
   end
   // ==================================================================
   // main sequence
   initial begin
      fpe_ctx_t    x;
      logic [15:0] et;
      logic [31:0] ea;
      cause = '0; ctx = '0; diff_count = '0; op_ok = 1'b0;
      reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0;
      fail_count = 0; tests_run = 0; resetn = 1'b0;
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      // reset values, unmapped and read-only places
      chk("run", 32'(1'b1), 32'(run));
      rd(OFS_TASK, 32'h0, "task");
      rd(OFS_ADDR_LO, 32'h0, "addr_lo");
      rd(OFS_ADDR_HI, 32'h0, "addr_hi");
      rd(OFS_FLAGS, 32'h0, "flags");
      rd(OFS_CTRL, 32'(STOP_RST), "stop_sel", 32'h1);
      rd(8'h20, 32'h0, "unmapped");
      wr(OFS_TASK, 32'h0000FFFF);
      rd(OFS_TASK, 32'h0, "task_ro");
      // count at the limit does not stop
      fire('0, '0, 18'd131071);
      chk("run_limit", 32'(1'b1), 32'(run));
      // continue mode: only the error flags and sticky events move
      wr(OFS_MASK, 32'h1);
      rd(OFS_STAT, 32'h0, "stat0");
      fire(10'h020, '0);
      chk("run_op_err", 32'(1'b1), 32'(run));
      rd(OFS_ERRS, 32'h1, "op_err");
      rd(OFS_FLAGS, 32'h0, "flags_op_err");
      @(posedge clock);
      op_ok <= 1'b1;
      @(posedge clock);
      op_ok <= 1'b0;
      rd(OFS_ERRS, 32'h0, "op_err_clr");
      fire(10'h010, '0);
      // access error sets access flag only
      rd(OFS_ERRS, 32'h2, "acc_err");
      wr(OFS_ERRS, 32'h0);
      fire(10'h008, '0);
      rd(OFS_ERRS, 32'h2, "acc_err_dec");
      chk("irq_masked", 32'(1'b0), 32'(irq));
      wr(OFS_MASK, 32'h4);
      chk("irq_acc", 32'(1'b1), 32'(irq));
      rd(OFS_MASK, 32'h4, "mask");
      rd(OFS_STAT, 32'h6, "stat_cont");
      chk("irq_clr", 32'(1'b0), 32'(irq));
      // stop mode: every cause in turn, fatal interrupt enabled
      wr(OFS_MASK, 32'h1);
      wr(OFS_CTRL, 32'h1);
      for (int i = 0; i < 10; i++) begin
         x.is_int = i[0];
         x.num    = i[0] ? (i == 3 ? 8'hFF : 8'(i * 20))
                         : (i == 0 ? 8'd31 : 8'(i));
         x.addr   = 32'h01234560 + 32'(i);
         et = (i == 1) ? TASK_NONE
            : (x.is_int ? (TASK_INT_BASE | 16'(x.num)) : 16'(x.num));
         ea = (i >= 1 && i <= 3) ? ADDR_TASK_ERR : x.addr;
         // count above the limit alone, beside its context
         fire(fpe_cause_t'((i == 7) ? 10'h000 : 10'h200 >> i), x,
              (i == 7) ? 18'd131072 : 18'd0);
         chk("run_stop", 32'(1'b0), 32'(run));
         rd(OFS_TASK, 32'(et), "task");
         rd(OFS_ADDR_LO, 32'(ea[15:0]), "addr_lo");
         rd(OFS_ADDR_HI, 32'(ea[31:16]), "addr_hi");
         rd(OFS_FLAGS, 32'h1 << flag_of[i], "flags");
         chk("irq_fatal", 32'(1'b1), 32'(irq));
         rd(OFS_STAT, 32'h1, "stat_fatal", 32'h1);
         chk("irq_read", 32'(1'b0), 32'(irq));
         // a later event leaves the capture alone
         fire(10'h001, '{1'b0, 8'd5, 32'h0000ABCD});
         rd(OFS_TASK, 32'(et), "task_hold");
         rd(OFS_ADDR_LO, 32'(ea[15:0]), "addr_hold");
         rd(OFS_FLAGS, 32'h1 << flag_of[i], "flags_hold");
         wr(OFS_CTRL, 32'h3);
         chk("run_clr", 32'(1'b1), 32'(run));
         rd(OFS_FLAGS, 32'h0, "flags_clr");
      end
      // a second reset in mid-run wipes a capture
      fire(10'h001, '{1'b1, 8'd7, 32'h00000042});
      rd(OFS_TASK, 32'h00008007, "task_pre");
      @(posedge clock);
      resetn <= 1'b0;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      #1;
      chk("run_rst", 32'(1'b1), 32'(run));
      rd(OFS_FLAGS, 32'h0, "flags_rst");
      rd(OFS_TASK, 32'h0, "task_rst");
      rd(OFS_CTRL, 32'(STOP_RST), "stop_rst", 32'h1);
      end_of_test();
   end
endmodule // test_fpe_capture
